// *** core/brbsm_ctrl.v ***
// boot rom bank switching, rom byte assembly and dram shadow decode
`timescale 1ns/1ps
`include "brbsm_defines.vh"

module brbsm_ctrl
(
  input  wire        mclk,
  input  wire        reset,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // processor memory port
  input  wire [19:0] cpu_addr,
  input  wire        cpu_rd,
  input  wire        cpu_wr,
  input  wire [15:0] cpu_wdata,
  output reg  [15:0] cpu_rdata,
  output reg         cpu_done,
  // rom sockets
  output reg  [19:0] rom_addr,
  output reg         rom_cs_n,
  output reg         rom_oe_n,
  input  wire [7:0]  rom_data,
  output reg  [3:0]  upper_rom_address_lines,
  output reg  [3:0]  second_socket_upper_lines,
  // dram
  output reg  [21:0] dram_addr,
  output reg         dram_rd,
  output reg         dram_wr,
  output reg  [15:0] dram_wdata,
  input  wire [15:0] dram_rdata,
  // bus fall-through
  output reg         ext_sel
);

  localparam [5:0] ST_IDLE  = 6'b000001;
  localparam [5:0] ST_ROM0  = 6'b000010;
  localparam [5:0] ST_ROM1  = 6'b000100;
  localparam [5:0] ST_DRAM  = 6'b001000;
  localparam [5:0] ST_DONE  = 6'b010000;
  localparam [5:0] ST_EXT   = 6'b100000;

  reg  [5:0]  state;
  reg  [3:0]  bank;
  reg  [9:0]  cfg;
  reg  [7:0]  low_byte;
  reg  [15:0] hold_wdata;
  reg         hold_wr;
  reg         tmr_load;
  reg  [3:0]  tmr_count;
  wire        tmr_done;
  wire [7:0]  page_rd;

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  wire [1:0] dram_size = cfg[`BRBSM_CFG_SIZE_HI:`BRBSM_CFG_SIZE_LO];
  wire [2:0] rom_type  = cfg[`BRBSM_CFG_ROMT_HI:`BRBSM_CFG_ROMT_LO];
  wire big_dram  = (dram_size != `BRBSM_DSZ_512K);                  // [R11] [R14]
  wire huge_dram = (dram_size == `BRBSM_DSZ_2M) || (dram_size == `BRBSM_DSZ_4M);
  wire sys_shd   = cfg[`BRBSM_CFG_SYS_SHD] && big_dram;              // [R11]
  wire vid_shd   = cfg[`BRBSM_CFG_VID_SHD] && big_dram;              // [R13]
  wire ems_on    = cfg[`BRBSM_CFG_EMS] && huge_dram;                 // [R16]
  wire reloc_on  = cfg[`BRBSM_CFG_RELOC] && big_dram && !ems_on;     // [R14] [R16]

  // rom byte wait count; only its low bits reach the 4-bit wait timer
  localparam [31:0] ROM_WS_FULL = `BRBSM_ROM_WS;

  // ----------------------------------------
  // address regions
  // ----------------------------------------
  wire in_sys  = (cpu_addr[19:16] == `BRBSM_SYS_BIOS_SEG);
  wire in_vid  = (cpu_addr[19:15] == `BRBSM_VID_BIOS_SEG);
  wire in_ems  = (cpu_addr[19:16] == `BRBSM_EMS_SEG);
  wire in_conv = (cpu_addr[19:16] < `BRBSM_CONV_TOP_SEG);
  wire in_reloc = (cpu_addr[19:16] == 4'he);
  // a 512k array has nothing behind the 80000-9ffff part of low memory
  wire hit_conv = in_conv && (big_dram || !cpu_addr[19]);            // [R10]
  wire rom_sel = (in_sys && !sys_shd) && !cpu_wr;                    // [R12]
  wire shd_sel = (in_sys && sys_shd) || (in_vid && vid_shd);         // [R12] [R13]

  // ----------------------------------------
  // rom socket sizing
  // ----------------------------------------
  // upper rom_addr pins that the fitted part lacks are held low, so a bank value meant
  // for a bigger part cannot alias into a wrong slice of a small one
  reg  [3:0]  rom_keep;
  wire [19:0] rom_base;
  always @*
  begin
    case (rom_type)                                                  // [R7]
      `BRBSM_ROM_64K:   rom_keep = 4'b0000;
      `BRBSM_ROM_128K:  rom_keep = 4'b0001;
      `BRBSM_ROM_256K:  rom_keep = 4'b0011;
      `BRBSM_ROM_F256K: rom_keep = 4'b0011;
      `BRBSM_ROM_512K:  rom_keep = 4'b0111;
      `BRBSM_ROM_F512K: rom_keep = 4'b0111;
      default:          rom_keep = 4'b1111;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_rom_upper
      assign rom_base[16 + gi] = bank[gi] && rom_keep[gi];           // [R17] [R5]
    end
  endgenerate
  assign rom_base[15:0] = {cpu_addr[15:1], 1'b0};                    // [R17]

  // dram address: shadow copies live at the same address as the range they replace
  reg [21:0] next_dram;
  always @*
  begin
    next_dram = {2'h0, cpu_addr};
    if (shd_sel)
      next_dram = {2'h0, cpu_addr};                                  // [R12] same address
    else if (ems_on && in_ems)
      next_dram = {page_rd, cpu_addr[13:0]};                         // [R15]
    else if (reloc_on && in_reloc)
      next_dram = {2'h0, 4'h1, cpu_addr[15:0]};                      // [R14]
  end

  wire dram_hit = shd_sel || hit_conv || (ems_on && in_ems) ||
                  (reloc_on && in_reloc);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  brbsm_wait_timer u_timer
  (
    .mclk  (mclk),
    .reset (reset),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  brbsm_page_mem u_pages
  (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (reg_wr && reg_addr[3:2] == 2'h1),
    .wr_idx  (reg_addr[1:0]),
    .wr_data (reg_wdata[7:0]),
    .rd_idx  (cpu_addr[15:14]),
    .rd_data (page_rd)
  );

  // ----------------------------------------
  // register port
  // ----------------------------------------
  wire wr_bank = reg_wr && (reg_addr == `BRBSM_REG_BANK);
  wire wr_cfg  = reg_wr && (reg_addr == `BRBSM_REG_CFG);

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      bank      <= `BRBSM_BANK_RESET;                                // [R6]
      cfg       <= `BRBSM_CFG_RESET;                                 // [R9]
      reg_rdata <= 16'h0000;
    end
    else
    begin
      if (wr_bank)
        bank <= reg_wdata[3:0];                                      // [R4]
      if (wr_cfg)
        cfg <= reg_wdata[9:0];                                       // [R8]
      if (reg_rd)
      begin
        case (reg_addr)
          `BRBSM_REG_BANK:   reg_rdata <= {12'h000, bank};
          `BRBSM_REG_CFG:    reg_rdata <= {6'h00, cfg};
          `BRBSM_REG_STATUS: reg_rdata <= {8'h00, state, sys_shd, ems_on};
          default:           reg_rdata <= 16'h0000;
        endcase
      end
      else
        reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  // page lookup needs one cycle, so the page index is sampled in idle and
  // the dram address is taken three or more cycles later in the dram state
  // the request level still stands at the edge that shows cpu_done; that
  // edge must not open a second access
  wire take_req = (cpu_rd || cpu_wr) && !cpu_done;

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state       <= ST_IDLE;
      cpu_rdata   <= 16'h0000;
      cpu_done    <= 1'b0;
      rom_addr    <= 20'h00000;
      rom_cs_n    <= 1'b1;
      rom_oe_n    <= 1'b1;
      low_byte    <= 8'h00;
      dram_addr   <= 22'h000000;
      dram_rd     <= 1'b0;
      dram_wr     <= 1'b0;
      dram_wdata  <= 16'h0000;
      hold_wdata  <= 16'h0000;
      hold_wr     <= 1'b0;
      tmr_load    <= 1'b0;
      tmr_count   <= 4'h0;
      ext_sel     <= 1'b0;
    end
    else
    begin
      cpu_done <= 1'b0;
      tmr_load <= 1'b0;
      dram_rd  <= 1'b0;
      dram_wr  <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (take_req)
          begin
            hold_wdata <= cpu_wdata;
            hold_wr    <= cpu_wr;
            if (rom_sel)
            begin
              rom_addr  <= rom_base;                                 // [R1] even byte first
              rom_cs_n  <= 1'b0;
              rom_oe_n  <= 1'b0;
              tmr_load  <= 1'b1;
              tmr_count <= ROM_WS_FULL[3:0];                         // [R2]
              state     <= ST_ROM0;
            end
            else if (dram_hit)
            begin
              tmr_load  <= 1'b1;
              tmr_count <= {3'h0, cfg[`BRBSM_CFG_DRAM_WS]};          // [R8]
              state     <= ST_DRAM;
            end
            else
            begin
              ext_sel <= 1'b1;
              state   <= ST_EXT;
            end
          end
        end
        ST_ROM0:
        begin
          if (tmr_done)
          begin
            low_byte  <= rom_data;                                   // [R1]
            rom_addr  <= {rom_addr[19:1], 1'b1};
            tmr_load  <= 1'b1;
            tmr_count <= ROM_WS_FULL[3:0];                           // [R2]
            state     <= ST_ROM1;
          end
        end
        ST_ROM1:
        begin
          if (tmr_done)
          begin
            cpu_rdata <= {rom_data, low_byte};                       // [R1]
            rom_cs_n  <= 1'b1;
            rom_oe_n  <= 1'b1;
            state     <= ST_DONE;
          end
        end
        ST_DRAM:
        begin
          if (tmr_done)
          begin
            dram_addr  <= next_dram;                                 // [R12] [R15]
            dram_rd    <= !hold_wr;
            dram_wr    <= hold_wr;
            dram_wdata <= hold_wdata;
            state      <= ST_DONE;
          end
        end
        ST_EXT:
        begin
          ext_sel <= 1'b0;
          state   <= ST_DONE;
        end
        ST_DONE:
        begin
          if (dram_rd)
            cpu_rdata <= dram_rdata;
          cpu_done <= 1'b1;
          state    <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // upper address lines of both sockets
  // ----------------------------------------
  // the pins are registers of their own, loaded by the same bank write, so a write shows on them at the
  // same edge at which it lands in the register
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      upper_rom_address_lines   <= `BRBSM_BANK_RESET;
      second_socket_upper_lines <= `BRBSM_BANK_RESET;
    end
    else if (wr_bank)
    begin
      upper_rom_address_lines   <= reg_wdata[3:0];                   // [R3] [R4]
      second_socket_upper_lines <= reg_wdata[3:0];                   // [R3]
    end
  end

endmodule // brbsm_ctrl

// *** core/brbsm_defines.vh ***
// constants for the boot rom bank and shadow memory controller
// Notes on behaviour
// R1: a 16-bit boot rom read becomes two byte reads, assembled into one word.
// R2: every boot rom access takes several wait states, more than dram.
// R3: upper rom address lines of both sockets come from software bank bits.
// R4: the bank register drives the upper rom pins; writing it changes the bank.
// R5: large roms are reached piecewise through a window selected by bank.
// R6: by default the bios image lies in the upper 64k of a 128k rom.
// R7: socket decode supports rom sizes 64k to 1m and flash 256k/512k.
// R8: dram uses zero or one wait states, chosen by configuration.
// R9: the default configuration selects one dram wait state.
// R10: dram arrays of 512k, 1m, 2m or 4m bytes are supported.
// R11: shadowing is offered only with at least 1m of dram fitted.
// R12: with shadowing on, rom decode is off and dram serves the range.
// R13: the video bios range can be shadowed into dram by configuration.
// R14: with 1m or more dram, unused dram is relocatable above 1m; the code maps the e segment onto dram at 10000-1ffff instead.
// R15: bank-switched pages reach dram beyond 640k as expanded memory.
// R16: with 2m or 4m dram, memory above 1m is extended or expanded.
// R17: rom address is low processor bits joined with the held bank bits.
`ifndef BRBSM_DEFINES_VH
`define BRBSM_DEFINES_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define BRBSM_REG_BANK      4'h0
`define BRBSM_REG_CFG       4'h1
`define BRBSM_REG_STATUS    4'h2
`define BRBSM_REG_PAGE0     4'h4

// ----------------------------------------
// configuration register fields
// ----------------------------------------
`define BRBSM_CFG_DRAM_WS   0
`define BRBSM_CFG_SYS_SHD   1
`define BRBSM_CFG_VID_SHD   2
`define BRBSM_CFG_RELOC     3
`define BRBSM_CFG_EMS       4
`define BRBSM_CFG_SIZE_LO   5
`define BRBSM_CFG_SIZE_HI   6
`define BRBSM_CFG_ROMT_LO   7
`define BRBSM_CFG_ROMT_HI   9

// ----------------------------------------
// reset values
// ----------------------------------------
`define BRBSM_BANK_RESET    4'h1
`define BRBSM_CFG_RESET     10'h081
`define BRBSM_PAGE_RESET    8'h00

// ----------------------------------------
// dram sizes
// ----------------------------------------
`define BRBSM_DSZ_512K      2'h0
`define BRBSM_DSZ_1M        2'h1
`define BRBSM_DSZ_2M        2'h2
`define BRBSM_DSZ_4M        2'h3

// ----------------------------------------
// rom types: 64k,128k,256k,512k,1m eprom, 256k,512k flash
// ----------------------------------------
`define BRBSM_ROM_64K       3'h0
`define BRBSM_ROM_128K      3'h1
`define BRBSM_ROM_256K      3'h2
`define BRBSM_ROM_512K      3'h3
`define BRBSM_ROM_1M        3'h4
`define BRBSM_ROM_F256K     3'h5
`define BRBSM_ROM_F512K     3'h6

// ----------------------------------------
// timing
// ----------------------------------------
`define BRBSM_CLK_NS        20
`define BRBSM_ROM_ACC_NS    200
`define BRBSM_ROM_WS        (((`BRBSM_ROM_ACC_NS + `BRBSM_CLK_NS - 1) / `BRBSM_CLK_NS))

// ----------------------------------------
// address regions, in 64k/32k units of the 1m space
// ----------------------------------------
`define BRBSM_SYS_BIOS_SEG  4'hf
`define BRBSM_VID_BIOS_SEG  5'h18
`define BRBSM_CONV_TOP_SEG  4'ha
`define BRBSM_EMS_SEG       4'hd

`endif

// *** core/brbsm_page_mem.v ***
// page-mapping memory for expanded memory windows
`timescale 1ns/1ps
`include "brbsm_defines.vh"

module brbsm_page_mem
(
  input  wire       mclk,
  input  wire       reset,
  input  wire       wr_en,
  input  wire [1:0] wr_idx,
  input  wire [7:0] wr_data,
  input  wire [1:0] rd_idx,
  output reg  [7:0] rd_data
);

  reg [7:0] page [0:3];
  genvar i;

  // ----------------------------------------
  // page entries
  // ----------------------------------------
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_page
      always @(posedge mclk or posedge reset)
      begin
        if (reset)
          page[i] <= `BRBSM_PAGE_RESET;
        else if (wr_en && wr_idx == i)
          page[i] <= wr_data; // [R15]
      end
    end
  endgenerate

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      rd_data <= `BRBSM_PAGE_RESET;
    else
      rd_data <= page[rd_idx];
  end

endmodule // brbsm_page_mem

// *** core/brbsm_wait_timer.v ***
// wait state counter for memory cycles
`timescale 1ns/1ps
`include "brbsm_defines.vh"

module brbsm_wait_timer
(
  input  wire       mclk,
  input  wire       reset,
  input  wire       load,
  input  wire [3:0] count,
  output reg        done
);

  reg [3:0] remain;
  reg       busy;

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      remain <= 4'h0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end
    else if (load)
    begin
      remain <= count;
      busy   <= 1'b1;
      done   <= 1'b0;
    end
    else if (busy)
    begin
      if (remain == 4'h0)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else
      begin
        remain <= remain - 4'h1;
        done   <= 1'b0;
      end
    end
    else
      done <= 1'b0;
  end

endmodule // brbsm_wait_timer

// *** testbench/brbsm_assertions.sv ***
// concurrent checks on the ports of the boot rom bank and shadow controller
`timescale 1ns/1ps
`include "brbsm_defines.vh"

module brbsm_assertions
(
  input wire        mclk,
  input wire        reset,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire [19:0] cpu_addr,
  input wire        cpu_done,
  input wire [19:0] rom_addr,
  input wire        rom_cs_n,
  input wire [3:0]  upper_rom_address_lines,
  input wire [3:0]  second_socket_upper_lines,
  input wire        dram_rd,
  input wire        dram_wr
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_bank_both_sockets: assert property (
    upper_rom_address_lines == second_socket_upper_lines) else $error("socket bank lines differ");
  a_bank_write_lands: assert property (
    reg_wr && reg_addr == `BRBSM_REG_BANK |=> upper_rom_address_lines == $past(reg_wdata[3:0]))
    else $error("bank write not on upper lines");
  a_bank_held_still: assert property (
    !(reg_wr && reg_addr == `BRBSM_REG_BANK) |=> $stable(upper_rom_address_lines))
    else $error("bank lines moved without write");
  a_rom_addr_form: assert property (
    !rom_cs_n |-> rom_addr[19:16] == upper_rom_address_lines && rom_addr[15:1] == cpu_addr[15:1])
    else $error("rom address not bank plus low bits");
  a_rom_even_first: assert property (
    $fell(rom_cs_n) |-> !rom_addr[0] ##[1:30] (rom_addr[0] && !rom_cs_n))
    else $error("rom bytes not even then odd");
  a_rom_long_wait: assert property (
    $fell(rom_cs_n) |-> !rom_cs_n [*8]) else $error("rom access too short");
  a_rom_then_done: assert property (
    $rose(rom_cs_n) |-> ##[0:2] cpu_done) else $error("no done after rom word");
  a_dram_then_done: assert property (
    (dram_rd || dram_wr) |=> cpu_done) else $error("no done after dram pulse");
endmodule // brbsm_assertions

bind brbsm_ctrl brbsm_assertions u_chk (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .cpu_addr, .cpu_done,
  .rom_addr, .rom_cs_n, .upper_rom_address_lines, .second_socket_upper_lines, .dram_rd, .dram_wr);

// *** testbench/brbsm_ctrl_tb.sv ***
// self-checking bench for the boot rom bank and shadow controller
`timescale 1ns/1ps
`include "brbsm_defines.vh"

module brbsm_ctrl_tb;
  logic        mclk      = 1'b0;
  logic        reset     = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [19:0] cpu_addr  = 20'h00000;
  logic        cpu_rd    = 1'b0;
  logic        cpu_wr    = 1'b0;
  logic [15:0] cpu_wdata = 16'h0000;
  wire  [15:0] reg_rdata, cpu_rdata, dram_wdata, dram_rdata;
  wire  [19:0] rom_addr;
  wire  [21:0] dram_addr;
  wire  [7:0]  rom_data;
  wire  [3:0]  upper_rom_address_lines, second_socket_upper_lines;
  wire         cpu_done, rom_cs_n, rom_oe_n, dram_rd, dram_wr, ext_sel;
  integer      err_total  = 0;
  integer      n_compared = 0;
  integer      seed       = 32'h56e1ce53;
  integer      cyc, c0, c1, rom_cyc, i;
  logic [1:0]  path;
  logic [15:0] d, w, off;
  logic [3:0]  b;

  always #10 mclk = ~mclk;

  brbsm_ctrl dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_addr, .cpu_rd,
    .cpu_wr, .cpu_wdata, .cpu_rdata, .cpu_done, .rom_addr, .rom_cs_n, .rom_oe_n, .rom_data,
    .upper_rom_address_lines, .second_socket_upper_lines, .dram_addr, .dram_rd, .dram_wr, .dram_wdata,
    .dram_rdata, .ext_sel);
  brbsm_mem_model mem (.mclk, .rom_addr, .rom_cs_n, .rom_oe_n, .rom_data, .dram_addr, .dram_rd, .dram_wr,
    .dram_wdata, .dram_rdata);

  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic [15:0] rom_word(input logic [3:0] bk, input logic [15:0] o);
    logic [7:0] e;
    e = {o[7:1], 1'b0} ^ {bk, o[11:8]};
    rom_word = {e ^ 8'h01, e};
  endfunction

  task automatic stop_test;
    $display("counts: %0d mismatches in %0d compares", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic reg_w(input logic [3:0] ad, input logic [15:0] wd);
    @(posedge mclk);
    reg_addr  <= ad;
    reg_wdata <= wd;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_r(input logic [3:0] ad, output logic [15:0] rd);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(posedge mclk);
    rd = reg_rdata;
  endtask

  // request held until done is seen; path 1 rom, 2 dram, 3 off-board, 0 none
  task automatic cpu_acc(input logic wr, input logic [19:0] ad, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge mclk);
    cpu_addr  <= ad;
    cpu_wdata <= wd;
    cpu_rd    <= !wr;
    cpu_wr    <= wr;
    path = 2'd0;
    cyc  = 0;
    do
    begin
      @(posedge mclk);
      cyc = cyc + 1;
      if (rom_cs_n === 1'b0)
        path = 2'd1;
      if (dram_rd === 1'b1 || dram_wr === 1'b1)
        path = 2'd2;
      if (ext_sel === 1'b1)
        path = 2'd3;
    end while (cpu_done !== 1'b1 && cyc < 200);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    rd = cpu_rdata;
    if (cyc >= 200)
    begin
      err_total = err_total + 1;
      $display("mismatch at %0t: no done", $time);
      stop_test();
    end
  endtask

  task automatic scen(input logic [15:0] cfg, input logic [19:0] ad, input logic to_dram);
    reg_w(`BRBSM_REG_CFG, cfg);
    w = $random(seed) | 16'h0001;
    cpu_acc(1'b1, ad, w, d);
    cpu_acc(1'b0, ad, 16'h0000, d);
    chk_flag(path == 2'd2, to_dram);
    chk_flag(path == 2'd3, !to_dram && ad[19:16] != 4'hf);
    if (to_dram)
      chk(d, w);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    reg_r(`BRBSM_REG_BANK, d);
    chk(d, {12'h000, `BRBSM_BANK_RESET});
    reg_r(`BRBSM_REG_CFG, d);
    chk(d, {6'h00, `BRBSM_CFG_RESET});
    reg_w(4'h9, 16'hffff);
    reg_r(4'h3, d);
    chk(d, 16'h0000);
    cpu_acc(1'b0, 20'hf0000 | ($random(seed) & 20'h0fffe), 16'h0000, d);
    chk(d, rom_word(`BRBSM_BANK_RESET, cpu_addr[15:0]));
    chk_flag(path == 2'd1, 1'b1);
    rom_cyc = cyc;
    reg_w(`BRBSM_REG_CFG, 16'h0201);
    for (i = 0; i < 6; i = i + 1)
    begin
      b = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
      reg_w(`BRBSM_REG_BANK, {12'h000, b});
      @(negedge mclk);
      chk({12'h000, second_socket_upper_lines}, {12'h000, b});
      chk({12'h000, upper_rom_address_lines}, {12'h000, b});
      off = $random(seed) & 16'hfffe;
      cpu_acc(1'b0, {4'hf, off}, 16'h0000, d);
      chk(d, rom_word(b, off));
    end
    reg_w(`BRBSM_REG_BANK, 16'h0001);
    // one then zero dram wait states on a conventional address
    scen(16'h0021, 20'h01230, 1'b1);
    c1 = cyc;
    scen(16'h0020, 20'h01230, 1'b1);
    c0 = cyc;
    chk_flag(c1 == c0 + 1, 1'b1);
    chk_flag(rom_cyc > c1 + 5, 1'b1);
    scen(16'h0023, 20'hf4000, 1'b1);
    scen(16'h0083, 20'hf4000, 1'b0);
    scen(16'h0001, 20'h81230, 1'b0);
    scen(16'h0021, 20'h81230, 1'b1);
    scen(16'h0025, 20'hc0100, 1'b1);
    scen(16'h0021, 20'hc0100, 1'b0);
    scen(16'h0029, 20'he0020, 1'b1);
    scen(16'h0021, 20'he0020, 1'b0);
    scen(16'h0031, 20'hd0010, 1'b0);
    reg_w(`BRBSM_REG_PAGE0, 16'h0003);
    scen(16'h0051, 20'hd0010, 1'b1);
    reg_w(`BRBSM_REG_PAGE0, 16'h0004);
    cpu_acc(1'b0, 20'hd0010, 16'h0000, d);
    chk_flag(d == w, 1'b0);
    stop_test();
  end
endmodule // brbsm_ctrl_tb

// *** testbench/brbsm_mem_model.sv ***
// behavioural rom socket and dram array on the far side of the controller
`timescale 1ns/1ps

module brbsm_mem_model
(
  input  wire         mclk,
  input  wire  [19:0] rom_addr,
  input  wire         rom_cs_n,
  input  wire         rom_oe_n,
  output logic [7:0]  rom_data,
  input  wire  [21:0] dram_addr,
  input  wire         dram_rd,
  input  wire         dram_wr,
  input  wire  [15:0] dram_wdata,
  output logic [15:0] dram_rdata
);
  logic [15:0] mem [0:8191];
  // the array folds the address to page bits plus a short line, which keeps
  // every location the bench uses apart
  wire  [12:0] slot = {dram_addr[21:14], dram_addr[5:1]};

  initial
    for (int k = 0; k < 8192; k++)
      mem[k] = 16'h0000;
  logic [15:0] q    = 16'h0000;
  logic        hold = 1'b0;
  logic [7:0]  last = 8'h00;

  // deselected rom shows the inverse of its last byte, so a late sample never matches
  always @*
    if (!rom_cs_n && !rom_oe_n)
      rom_data = rom_addr[7:0] ^ {rom_addr[19:16], rom_addr[11:8]};
    else
      rom_data = ~last;

  // read word is shown in the strobe cycle and the one after, then it turns over
  assign dram_rdata = dram_rd ? mem[slot] : (hold ? q : ~q);

  always @(posedge mclk)
  begin
    if (!rom_cs_n)
      last <= rom_data;
    if (dram_wr)
      mem[slot] <= dram_wdata;
    hold <= dram_rd;
    q    <= dram_rdata;
  end
endmodule // brbsm_mem_model
